//--- shared/crc_map.svh
`ifndef CRC_MAP_SVH
`define CRC_MAP_SVH

// Master clock period and power-on hold time, both in ns
`define CRC_CLK_PERIOD_NS 10
`define CRC_POR_TIME_NS 20000

// Master clock divide ratios for the system clock
`define CRC_DIV_HIGH 10
`define CRC_DIV_LOW 1000

// Width of the divider counter
`define CRC_DIV_W 10

// Scan pulse timing field width in bits; the fields count system clock ticks
`define CRC_SCAN_W 16

// Configuration byte
`define CRC_CFG_W 8
`define CRC_CFG_RESET 8'h00

// Pin levels
`define CRC_MCLK_EXT 1'b0
`define CRC_MCLK_INT 1'b1
`define CRC_CANCLK_MCLK 1'b0
`define CRC_CANCLK_PAD 1'b1
`define CRC_RATE_LOW 1'b0
`define CRC_RATE_HIGH 1'b1
`define CRC_MODE_LOCAL 1'b0
`define CRC_MODE_REMOTE 1'b1

`endif

//--- shared/crc_pkg.sv
package crc_pkg;

	typedef enum logic [1:0] {
		OP_RESET,
		OP_IDLE,
		OP_RUN
	} crc_op_t;

	// Pending CAN system clock override
	typedef struct packed {
		logic valid;
		logic high;
	} crc_rate_ovr_t;

	// Scan pulse timing in system clock ticks
	typedef struct packed {
		logic [15:0] period;
		logic [15:0] width;
	} crc_scan_cfg_t;

endpackage

//--- rtl/crc_clock_reset.sv
`timescale 1ns/1ps
`include "crc_map.svh"
module crc_clock_reset #(
	parameter int POR_CYCLES =
		(`CRC_POR_TIME_NS + `CRC_CLK_PERIOD_NS - 1) / `CRC_CLK_PERIOD_NS,
	parameter int DIV_HIGH = `CRC_DIV_HIGH,
	parameter int DIV_LOW = `CRC_DIV_LOW
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic master_reset_n,
	input wire logic mclk_source_sel,
	input wire logic can_clk_source_sel,
	input wire logic sys_clk_rate_sel,
	input wire logic operating_mode_sel,
	input wire logic can_rate_valid,
	input wire logic can_rate_high,
	input wire logic cfg_wr,
	input wire logic [`CRC_CFG_W-1:0] cfg_wdata,
	input wire logic nmt_node_reset,
	input wire logic nmt_comm_reset,
	input wire logic nmt_start,
	input wire logic scan_enable_in,
	input wire logic scan_seq_running,
	input wire crc_pkg::crc_scan_cfg_t scan_cfg,
	output logic mclk_internal_sel,
	output logic can_if_clk_pad_sel,
	output logic sys_clk_b,
	output logic sys_clk_high_active,
	output logic core_reset_n_out,
	output logic can_if_reset_n_out,
	output logic device_operational,
	output logic boot_up_req,
	output logic scan_running_out,
	output logic remote_terminal_mode,
	output logic standalone_mode,
	output logic [`CRC_CFG_W-1:0] cfg_active
);

	generate
		if (DIV_LOW > (1 << `CRC_DIV_W) || DIV_HIGH > (1 << `CRC_DIV_W) ||
			DIV_HIGH < 2 || DIV_LOW < 2 || POR_CYCLES < 1) begin : g_bad
			$error("crc_clock_reset: divider or POR count out of range");
		end
	endgenerate

	localparam logic [`CRC_DIV_W-1:0] TC_HIGH = `CRC_DIV_W'(DIV_HIGH - 1);
	localparam logic [`CRC_DIV_W-1:0] TC_LOW = `CRC_DIV_W'(DIV_LOW - 1);
	localparam int POR_W = $clog2(POR_CYCLES + 1);
	localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES);

	// Either pin resets everything but the power-on hold counter (reset_n only) without waiting for a clock edge
	logic async_rst_n;
	assign async_rst_n = reset_n & master_reset_n;

	logic remote;
	logic remote_q;
	assign remote = remote_q;

	// Mode and clock source selects, registered so they change glitch-free
	always_ff @(posedge sys_clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			remote_q <= 1'b0;
			mclk_internal_sel <= `CRC_MCLK_EXT;
			can_if_clk_pad_sel <= `CRC_CANCLK_MCLK;
		end else begin
			remote_q <= (operating_mode_sel == `CRC_MODE_REMOTE);
			mclk_internal_sel <= (mclk_source_sel == `CRC_MCLK_INT);
			// Pad clock for the CAN side is only offered in remote mode
			can_if_clk_pad_sel <= (operating_mode_sel == `CRC_MODE_REMOTE) &&
				(can_clk_source_sel == `CRC_CANCLK_PAD);
		end
	end

	assign remote_terminal_mode = remote_q;
	assign standalone_mode = ~remote_q;

	// Power-on hold: counted once after the power reset only, so a master
	// reset does not repeat the full hold
	logic [POR_W-1:0] por_cnt_q;
	logic por_done_q;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			por_cnt_q <= '0;
			por_done_q <= 1'b0;
		end else if (!por_done_q) begin
			por_cnt_q <= por_cnt_q + POR_W'(1);
			por_done_q <= (por_cnt_q == POR_LAST - POR_W'(1));
		end
	end

	// Core reset synchroniser; node reset in remote mode clears it on a clock edge
	logic core_s1_q;
	logic core_s2_q;
	logic core_ok_q;

	always_ff @(posedge sys_clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			core_s1_q <= 1'b0;
			core_s2_q <= 1'b0;
		end else if (nmt_node_reset && remote) begin
			core_s1_q <= 1'b0;
			core_s2_q <= 1'b0;
		end else begin
			core_s1_q <= 1'b1;
			core_s2_q <= core_s1_q;
		end
	end

	always_ff @(posedge sys_clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			core_ok_q <= 1'b0;
		end else begin
			core_ok_q <= core_s2_q & por_done_q;
		end
	end

	assign core_reset_n_out = core_ok_q;

	// CAN side reset synchroniser, also cleared by the communication reset in remote mode
	logic can_s1_q;
	logic can_s2_q;
	logic comm_hit;
	assign comm_hit = nmt_comm_reset && remote;

	always_ff @(posedge sys_clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			can_s1_q <= 1'b0;
			can_s2_q <= 1'b0;
		end else if (comm_hit || !core_ok_q) begin
			can_s1_q <= 1'b0;
			can_s2_q <= 1'b0;
		end else begin
			can_s1_q <= 1'b1;
			can_s2_q <= can_s1_q;
		end
	end

	assign can_if_reset_n_out = can_s2_q;

	// Operating state
	crc_pkg::crc_op_t op_q;

	always_ff @(posedge sys_clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			op_q <= crc_pkg::OP_RESET;
			boot_up_req <= 1'b0;
		end else if (!core_ok_q) begin
			op_q <= crc_pkg::OP_RESET;
			boot_up_req <= 1'b0;
		end else begin
			boot_up_req <= 1'b0;
			case (op_q)
			crc_pkg::OP_RESET: begin
				if (remote) begin
					// Wait for the CAN side to leave reset before booting
					if (can_s2_q) begin
						op_q <= crc_pkg::OP_IDLE;
						boot_up_req <= 1'b1;
					end
				end else begin
					op_q <= crc_pkg::OP_RUN;
				end
			end
			crc_pkg::OP_IDLE: begin
				if (nmt_start && can_s2_q) begin
					op_q <= crc_pkg::OP_RUN;
				end
			end
			crc_pkg::OP_RUN: begin
				if (comm_hit) begin
					op_q <= crc_pkg::OP_RESET;
				end
			end
			default: begin
				op_q <= crc_pkg::OP_RESET;
			end
			endcase
		end
	end

	assign device_operational = (op_q == crc_pkg::OP_RUN);

	// Scan sequence edge detection
	logic scan_prev_q;
	logic scan_rise;
	logic scan_fall;

	always_ff @(posedge sys_clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			scan_prev_q <= 1'b0;
		end else begin
			scan_prev_q <= scan_seq_running;
		end
	end

	assign scan_rise = scan_seq_running & ~scan_prev_q;
	assign scan_fall = ~scan_seq_running & scan_prev_q;

	// CAN rate override, remote mode only
	crc_pkg::crc_rate_ovr_t ovr_q;

	always_ff @(posedge sys_clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			ovr_q <= '0;
		end else if (!core_ok_q || !remote) begin
			ovr_q <= '0;
		end else if (can_rate_valid) begin
			ovr_q.valid <= 1'b1;
			ovr_q.high <= can_rate_high;
		end
	end

	logic rate_want;
	assign rate_want = ovr_q.valid ? ovr_q.high :
		(sys_clk_rate_sel == `CRC_RATE_HIGH);

	// System clock divider; terminal count moves only between sequences
	// so a running sequence never sees its tick rate change mid-way
	logic [`CRC_DIV_W-1:0] div_cnt_q;
	logic [`CRC_DIV_W-1:0] div_tc_q;
	logic tick;
	logic reload;

	assign tick = (div_cnt_q == div_tc_q);
	assign reload = scan_fall || (!scan_seq_running && tick);

	always_ff @(posedge sys_clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			div_cnt_q <= '0;
			div_tc_q <= TC_LOW;
			sys_clk_high_active <= `CRC_RATE_LOW;
		end else if (!core_ok_q) begin
			div_cnt_q <= '0;
			div_tc_q <= rate_want ? TC_HIGH : TC_LOW;
			sys_clk_high_active <= rate_want;
		end else begin
			if (tick || reload) begin
				div_cnt_q <= '0;
			end else begin
				div_cnt_q <= div_cnt_q + `CRC_DIV_W'(1);
			end
			if (reload) begin
				div_tc_q <= rate_want ? TC_HIGH : TC_LOW;
				sys_clk_high_active <= rate_want;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			sys_clk_b <= 1'b0;
		end else begin
			sys_clk_b <= core_ok_q & tick;
		end
	end

	// Configuration byte: held pending, applied at the next sequence start
	logic [`CRC_CFG_W-1:0] cfg_pend_q;

	always_ff @(posedge sys_clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			cfg_pend_q <= `CRC_CFG_RESET;
			cfg_active <= `CRC_CFG_RESET;
		end else if (!core_ok_q) begin
			cfg_pend_q <= `CRC_CFG_RESET;
			cfg_active <= `CRC_CFG_RESET;
		end else begin
			if (cfg_wr && remote) begin
				cfg_pend_q <= cfg_wdata;
			end
			if (scan_rise) begin
				cfg_active <= cfg_pend_q;
			end
		end
	end

	// Scan pulse generator for the local modes, in system clock ticks
	logic [`CRC_SCAN_W-1:0] pcnt_q;
	logic pulse_on;
	assign pulse_on = device_operational && !remote && scan_enable_in;

	always_ff @(posedge sys_clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			pcnt_q <= '0;
		end else if (!pulse_on) begin
			pcnt_q <= '0;
		end else if (tick) begin
			if (pcnt_q >= scan_cfg.period - `CRC_SCAN_W'(1)) begin
				pcnt_q <= '0;
			end else begin
				pcnt_q <= pcnt_q + `CRC_SCAN_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge async_rst_n) begin
		if (!async_rst_n) begin
			scan_running_out <= 1'b0;
		end else begin
			scan_running_out <= pulse_on && (pcnt_q < scan_cfg.width);
		end
	end

endmodule

//--- tb/crc_clock_reset_properties.sv
`timescale 1ns/1ps
`include "crc_map.svh"
module crc_clock_reset_properties (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic master_reset_n,
	input wire logic mclk_source_sel,
	input wire logic can_clk_source_sel,
	input wire logic operating_mode_sel,
	input wire logic nmt_node_reset,
	input wire logic nmt_comm_reset,
	input wire logic nmt_start,
	input wire logic scan_seq_running,
	input wire logic mclk_internal_sel,
	input wire logic can_if_clk_pad_sel,
	input wire logic sys_clk_b,
	input wire logic sys_clk_high_active,
	input wire logic core_reset_n_out,
	input wire logic can_if_reset_n_out,
	input wire logic device_operational,
	input wire logic boot_up_req,
	input wire logic remote_terminal_mode,
	input wire logic [`CRC_CFG_W-1:0] cfg_active
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n || !master_reset_n);
	mclk_select_a:
	assert property (core_reset_n_out && $past(core_reset_n_out, 2)
		|-> mclk_internal_sel == $past(mclk_source_sel))
		else $error("master clock select wrong");
	can_clock_a:
	assert property (core_reset_n_out && $past(core_reset_n_out, 2)
		|-> can_if_clk_pad_sel ==
		$past(can_clk_source_sel && operating_mode_sel))
		else $error("CAN clock select wrong");
	high_tick_a:
	assert property (sys_clk_b && sys_clk_high_active &&
		$past(sys_clk_high_active) && !$fell(scan_seq_running) ##1
		(!sys_clk_b && sys_clk_high_active && core_reset_n_out &&
		!$fell(scan_seq_running))[*8]
		##1 sys_clk_high_active |=> sys_clk_b || !core_reset_n_out)
		else $error("high rate tick spacing wrong");
	node_reset_a:
	assert property (remote_terminal_mode && nmt_node_reset
		|-> ##2 !core_reset_n_out) else $error("node reset missing");
	comm_reset_a:
	assert property (remote_terminal_mode && nmt_comm_reset &&
		!nmt_node_reset && !$past(nmt_node_reset) && core_reset_n_out
		|=> !can_if_reset_n_out && core_reset_n_out)
		else $error("comm reset wrong");
	boot_pulse_a:
	assert property ($rose(can_if_reset_n_out) && remote_terminal_mode
		|=> boot_up_req ##1 !boot_up_req) else $error("boot pulse wrong");
	start_cmd_a:
	assert property (remote_terminal_mode && nmt_start &&
		$past(can_if_reset_n_out, 2) && can_if_reset_n_out &&
		core_reset_n_out && !nmt_node_reset && !nmt_comm_reset
		|=> device_operational) else $error("start not taken");
	cfg_apply_a:
	assert property ($changed(cfg_active) |-> (cfg_active == 8'h00) ||
		($past(scan_seq_running) && !$past(scan_seq_running, 2)))
		else $error("config applied outside scan start");
endmodule
bind crc_clock_reset crc_clock_reset_properties crc_props_inst (.*);

//--- tb/crc_can_master.sv
`timescale 1ns/1ps
module crc_can_master (
	input wire logic sys_clk,
	input wire logic boot_up_req,
	input wire logic slow,
	output logic nmt_start
);
	initial nmt_start = 1'b0;
	// Start only follows a boot-up, never sent blind
	always @(posedge sys_clk) begin
		if (boot_up_req === 1'b1) begin
			repeat (slow ? 12 : 1) @(negedge sys_clk);
			nmt_start <= 1'b1;
			@(negedge sys_clk);
			nmt_start <= 1'b0;
		end
	end
endmodule

//--- tb/crc_clock_reset_tb.sv
`timescale 1ns/1ps
module crc_clock_reset_tb;
	logic sys_clk = 0, reset_n = 0, master_reset_n = 1, slow = 0;
	logic mclk_source_sel = 0, can_clk_source_sel = 0;
	logic sys_clk_rate_sel = 1, operating_mode_sel = 0;
	logic can_rate_valid = 0, can_rate_high = 0, cfg_wr = 0;
	logic nmt_node_reset = 0, nmt_comm_reset = 0, nmt_start;
	logic scan_enable_in = 0, scan_seq_running = 0;
	logic [7:0] cfg_wdata = 8'h00, cfg_active, e, d;
	crc_pkg::crc_scan_cfg_t scan_cfg = '{16'h0004, 16'h0002};
	logic mclk_internal_sel, can_if_clk_pad_sel, sys_clk_b;
	logic sys_clk_high_active, core_reset_n_out, can_if_reset_n_out;
	logic device_operational, boot_up_req, scan_running_out;
	logic remote_terminal_mode, standalone_mode;
	logic [15:0] g;
	logic [31:0] seed = 32'h7b12;
	int fail_count = 0, checks = 0, cyc = 0;
	always #5 sys_clk = ~sys_clk;
	crc_clock_reset #(.POR_CYCLES(8)) crc_clock_reset_inst (.*);
	crc_can_master crc_can_master_inst (.sys_clk, .boot_up_req, .slow,
		.nmt_start);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] exp_div(input logic hi);
		return hi ? 16'h000a : 16'h03e8;
	endfunction
	task chk(input string n, input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task cyc_n(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task pulse(input logic [3:0] m);
		{cfg_wr, can_rate_valid, nmt_comm_reset, nmt_node_reset} = m;
		@(negedge sys_clk);
		{cfg_wr, can_rate_valid, nmt_comm_reset, nmt_node_reset} = 0;
	endtask
	// Watched signal by code, read live on every falling edge
	function automatic logic sig(input int s);
		case (s)
		0: return core_reset_n_out;
		1: return device_operational;
		2: return scan_running_out;
		3: return boot_up_req;
		4: return sys_clk_b;
		5: return sys_clk_high_active;
		default: return ~scan_running_out;
		endcase
	endfunction
	task wait_for(input int s, input int lim, output logic [15:0] n);
		for (n = 0; n < lim && sig(s) !== 1'b1; n++) @(negedge sys_clk);
	endtask
	task mreset();
		master_reset_n = 0;
		cyc_n(2);
		master_reset_n = 1;
	endtask
	task tick_gap();
		wait_for(4, 3000, g);
		g = 0;
		do begin
			@(negedge sys_clk);
			g++;
		end while (sys_clk_b !== 1'b1 && g < 3000);
	endtask
	task give_verdict();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict();
		end
	end
	initial begin
		mclk_source_sel = 1'(xs());
		cyc_n(4);
		reset_n = 1;
		wait_for(0, 100, g);
		chk("por_len", g >= 8, 1);
		wait_for(1, 200, g);
		chk("local_run", device_operational, 1);
		chk("mclk_sel", mclk_internal_sel, mclk_source_sel);
		chk("can_pad", can_if_clk_pad_sel, 0);
		chk("standalone", standalone_mode, 1);
		tick_gap();
		chk("gap_high", g, exp_div(1));
		cyc_n(1);
		chk("tick_len", sys_clk_b, 0);
		scan_enable_in = 1;
		wait_for(2, 200, g);
		chk("scan_pulse", scan_running_out, 1);
		wait_for(6, 200, g);
		chk("scan_gap", scan_running_out, 0);
		sys_clk_rate_sel = 0;
		tick_gap();
		tick_gap();
		chk("gap_low", g, exp_div(0));
		// Remote needs the accurate pad clock
		mclk_source_sel = 0;
		operating_mode_sel = 1;
		can_clk_source_sel = 1'(xs());
		slow = 1;
		mreset();
		wait_for(0, 20, g);
		chk("mr_sync", g, 3);
		wait_for(3, 200, g);
		chk("idle_wait", device_operational, 0);
		wait_for(1, 200, g);
		chk("remote_run", device_operational, 1);
		chk("remote", remote_terminal_mode, 1);
		chk("can_pad_r", can_if_clk_pad_sel, can_clk_source_sel);
		slow = 0;
		scan_seq_running = 1;
		can_rate_high = 1;
		pulse(4'b0100);
		cyc_n(20);
		chk("rate_hold", sys_clk_high_active, 0);
		scan_seq_running = 0;
		wait_for(5, 20, g);
		chk("rate_new", sys_clk_high_active, 1);
		e = 8'h00;
		for (int i = 0; i < 4; i++) begin
			scan_seq_running = i % 2;
			cyc_n(2);
			d = 8'(xs());
			cfg_wdata = d;
			pulse(4'b1000);
			cyc_n(3);
			chk("cfg_hold", cfg_active, e);
			scan_seq_running = 0;
			cyc_n(2);
			scan_seq_running = 1;
			cyc_n(3);
			chk("cfg_apply", cfg_active, d);
			e = d;
		end
		scan_seq_running = 0;
		pulse(4'b0010);
		chk("core_kept", core_reset_n_out, 1);
		chk("comm_can", can_if_reset_n_out, 0);
		wait_for(1, 200, g);
		chk("comm_back", device_operational, 1);
		pulse(4'b0001);
		cyc_n(1);
		chk("node_core", core_reset_n_out, 0);
		cyc_n(1);
		chk("node_cfg", cfg_active, 0);
		chk("node_idle", device_operational, 0);
		wait_for(1, 200, g);
		chk("node_rate", sys_clk_high_active, 0);
		operating_mode_sel = 0;
		mreset();
		wait_for(1, 200, g);
		pulse(4'b0011);
		cyc_n(4);
		chk("local_ign", {core_reset_n_out, can_if_reset_n_out}, 3);
		give_verdict();
	end
endmodule
